// ==== rtl/cfg_rx_pkg.sv ====
package cfg_rx_pkg;
	// Serial and parallel load modes
	typedef enum logic
	{
		MODE_SERIAL,
		MODE_PARALLEL
	} load_mode_e;

	localparam int unsigned SYS_CLK_MHZ       = 50;
	// Request high to status release, default
	localparam int unsigned CF2ST1_MAX_US     = 230;
	localparam int unsigned CF2ST1_CYC        = CF2ST1_MAX_US * SYS_CLK_MHZ;
	// Done high to user mode with internal oscillator, least
	localparam int unsigned CD2UM_MIN_US      = 300;
	localparam int unsigned CD2UM_CYC         = CD2UM_MIN_US * SYS_CLK_MHZ;
	localparam int unsigned USR_INIT_CYC      = 3192;
	localparam int unsigned DONE_FALL_EDGES   = 2;
	localparam logic [31:0] IMAGE_BITS_DFLT   = 32'h0000_0400;
endpackage : cfg_rx_pkg

// ==== rtl/passive_config_receiver.sv ====
`timescale 1ns/1ps
// Notes on behaviour
// - In serial mode one data bit is shifted in per configuration clock.
// - User mode starts only once the shared done line is high.
// - A low shared status line stops data acceptance.
// - In parallel mode one whole byte is taken per configuration clock.
// - With cable load the user start-up clock is ignored.
// - A held-low request or status delays the start for as long as held.
// - An external low on status keeps the device waiting past the default release time.
// - The bounded done-to-user delay is counted only on the internal clock.
// - Request low in user mode abandons user mode and reconfigures.
// - A detected error pulls the shared status line low.
// - With the user start-up clock, 3192 of its cycles finish initialisation.
module passive_config_receiver
	import cfg_rx_pkg::*;
#(
	parameter int unsigned RELEASE_CYC = CF2ST1_CYC,
	parameter int unsigned STARTUP_CYC = CD2UM_CYC,
	parameter logic [31:0] IMAGE_BITS  = IMAGE_BITS_DFLT
)
(
	input  wire logic       i_clk_sys,
	input  wire logic       i_rst_b,
	input  wire logic       i_cfg_clk,
	input  wire logic       i_user_startup_clock,
	input  wire logic       i_mode_parallel,
	input  wire logic       i_cable_load,
	input  wire logic       i_usr_clk_sel,
	input  wire logic       i_auto_restart,
	input  wire logic       i_config_req_b,
	input  wire logic       i_status_b,
	input  wire logic       i_done,
	input  wire logic [7:0] i_data,
	input  wire logic       i_crc_error,
	output logic            o_status_b_oe,
	output logic            o_status_b_out,
	output logic            o_done_oe,
	output logic            o_done_out,
	output logic            o_user_mode,
	output logic            o_error
);
	typedef enum logic [2:0]
	{
		ST_RESET,
		ST_RELEASE,
		ST_LOAD,
		ST_WAIT_DONE,
		ST_INIT,
		ST_USER,
		ST_ERROR
	} cfg_state_e;

	// System side synchronisers
	logic [1:0] req_s_r, stat_s_r, done_s_r, mode_s_r, err_s_r;
	logic [1:0] fall_tog_s_r, usr_tog_s_r;
	logic [5:0] strap_s_r;
	logic       fall_tog_d_r, usr_tog_d_r, fall_tog_r, usr_tog_r;
	logic       req_b, stat_b, done_hi, par_mode, err_in, cab_in, sel_in, auto_in;
	logic [31:0] bits_s_r [2];

	always_ff @(posedge i_clk_sys)
	begin
		req_s_r      <= {req_s_r[0], i_config_req_b};
		stat_s_r     <= {stat_s_r[0], i_status_b};
		done_s_r     <= {done_s_r[0], i_done};
		mode_s_r     <= {mode_s_r[0], i_mode_parallel};
		err_s_r      <= {err_s_r[0], i_crc_error};
		strap_s_r    <= {strap_s_r[2:0], i_cable_load, i_usr_clk_sel, i_auto_restart};
		fall_tog_s_r <= {fall_tog_s_r[0], fall_tog_r};
		usr_tog_s_r  <= {usr_tog_s_r[0], usr_tog_r};
		fall_tog_d_r <= fall_tog_s_r[1];
		usr_tog_d_r  <= usr_tog_s_r[1];
	end

	assign req_b    = req_s_r[1];
	assign stat_b   = stat_s_r[1];
	assign done_hi  = done_s_r[1];
	assign par_mode = mode_s_r[1];
	assign err_in   = err_s_r[1];
	assign {cab_in, sel_in, auto_in} = strap_s_r[5:3];

	cfg_state_e  state_r, state_nxt;
	logic [31:0] cnt_r, cnt_nxt;
	logic [1:0]  fall_cnt_r, fall_cnt_nxt;
	logic        accept_r, accept_nxt;
	logic        done_drv_r, done_drv_nxt;
	logic        stat_low_r, stat_low_nxt;
	logic        usr_en_r, usr_en_nxt;
	logic        fall_ev, usr_ev, load_full, use_usr, cnt_clr_r, cnt_clr_nxt;

	assign fall_ev   = fall_tog_s_r[1] ^ fall_tog_d_r;
	assign usr_ev    = usr_tog_s_r[1] ^ usr_tog_d_r;
	assign use_usr   = sel_in & ~cab_in;
	assign load_full = cnt_clr_r && (bits_s_r[1] >= (par_mode ? IMAGE_BITS >> 3 : IMAGE_BITS));

	always_comb
	begin
		state_nxt    = state_r;
		cnt_nxt      = cnt_r;
		fall_cnt_nxt = fall_cnt_r;
		accept_nxt   = 1'b0;
		done_drv_nxt = done_drv_r;
		stat_low_nxt = 1'b0;
		usr_en_nxt   = 1'b0;
		cnt_clr_nxt  = 1'b0;
		unique case (state_r)
			ST_RESET:
			begin
				stat_low_nxt = 1'b1;
				done_drv_nxt = 1'b0;
				cnt_nxt      = '0;
				if (req_b)
					state_nxt = ST_RELEASE;
			end
			ST_RELEASE:
			begin
				// Release own status, then wait on any external hold
				if (cnt_r < RELEASE_CYC)
				begin
					stat_low_nxt = 1'b1;
					cnt_nxt      = cnt_r + 32'h0000_0001;
				end
				else if (stat_b)
					state_nxt = ST_LOAD;
			end
			ST_LOAD:
			begin
				accept_nxt = stat_b;
				cnt_clr_nxt = cnt_clr_r | (bits_s_r[1] == 32'h0000_0000);
				if (err_in)
					state_nxt = ST_ERROR;
				else if (load_full)
				begin
					done_drv_nxt = 1'b1;
					fall_cnt_nxt = '0;
					state_nxt    = ST_WAIT_DONE;
				end
			end
			ST_WAIT_DONE:
			begin
				if (fall_ev && done_hi && fall_cnt_r != 2'(DONE_FALL_EDGES))
					fall_cnt_nxt = fall_cnt_r + 2'h1;
				if (done_hi && fall_cnt_r == 2'(DONE_FALL_EDGES))
				begin
					cnt_nxt   = '0;
					state_nxt = ST_INIT;
				end
			end
			ST_INIT:
			begin
				usr_en_nxt = use_usr;
				if (use_usr ? usr_ev : 1'b1)
					cnt_nxt = cnt_r + 32'h0000_0001;
				if (cnt_r >= (use_usr ? USR_INIT_CYC : STARTUP_CYC))
					state_nxt = ST_USER;
			end
			ST_USER:
			begin
				// Nothing to do until a new request
			end
			ST_ERROR:
			begin
				stat_low_nxt = 1'b1;
				if (auto_in && !cab_in)
				begin
					cnt_nxt   = '0;
					state_nxt = ST_RELEASE;
				end
			end
			default:
				state_nxt = ST_RESET;
		endcase
		if (!req_b)
			state_nxt = ST_RESET;
	end

	always_ff @(posedge i_clk_sys)
	begin
		if (!i_rst_b)
		begin
			state_r    <= ST_RESET;
			cnt_r      <= '0;
			fall_cnt_r <= '0;
			accept_r   <= 1'b0;
			done_drv_r <= 1'b0;
			stat_low_r <= 1'b1;
			usr_en_r   <= 1'b0;
			cnt_clr_r  <= 1'b0;
		end
		else
		begin
			state_r    <= state_nxt;
			cnt_r      <= cnt_nxt;
			fall_cnt_r <= fall_cnt_nxt;
			accept_r   <= accept_nxt;
			done_drv_r <= done_drv_nxt;
			stat_low_r <= stat_low_nxt;
			usr_en_r   <= usr_en_nxt;
			cnt_clr_r  <= cnt_clr_nxt;
		end
	end

	assign o_status_b_oe  = stat_low_r;
	assign o_status_b_out = 1'b0;
	assign o_done_oe      = ~done_drv_r;
	assign o_done_out     = 1'b0;
	assign o_user_mode    = (state_r == ST_USER);
	assign o_error        = (state_r == ST_ERROR);

	// Link side: accept level crosses in, transfer count crosses out (gray)
	logic [1:0]  acc_l_r, rst_l_r, mode_l_r;
	logic [7:0]  shift_r, shift_nxt;
	logic [31:0] bits_r, bits_nxt, bits_g_r;
	logic [1:0]  usr_en_u_r;

	always_comb
	begin
		shift_nxt = shift_r;
		bits_nxt  = bits_r;
		if (!acc_l_r[1] || !rst_l_r[1])
			bits_nxt = '0;
		else if (mode_l_r[1])
		begin
			shift_nxt = i_data;
			bits_nxt  = bits_r + 32'h0000_0001;
		end
		else
		begin
			shift_nxt = {shift_r[6:0], i_data[0]};
			bits_nxt  = bits_r + 32'h0000_0001;
		end
	end

	always_ff @(posedge i_cfg_clk)
	begin
		rst_l_r  <= {rst_l_r[0], i_rst_b};
		mode_l_r <= {mode_l_r[0], i_mode_parallel};
		acc_l_r  <= {acc_l_r[0], accept_r};
		shift_r  <= shift_nxt;
		bits_r   <= bits_nxt;
		bits_g_r <= bits_nxt ^ (bits_nxt >> 1);
	end

	always_ff @(negedge i_cfg_clk)
		fall_tog_r <= rst_l_r[1] & ~fall_tog_r;

	// Start-up clock only toggles an event while initialisation asks for it
	always_ff @(posedge i_user_startup_clock)
	begin
		usr_en_u_r <= {usr_en_u_r[0], usr_en_r};
		usr_tog_r  <= usr_en_u_r[1] & ~usr_tog_r;
	end

	function automatic logic [31:0] gray2bin(input logic [31:0] g);
		logic [31:0] b;
		b = g;
		for (int i = 30; i >= 0; i--)
			b[i] = b[i + 1] ^ g[i];
		return b;
	endfunction : gray2bin

	logic [31:0] bits_sync_r;
	always_ff @(posedge i_clk_sys)
	begin
		bits_s_r[0] <= bits_g_r;
		bits_sync_r <= bits_s_r[0];
		bits_s_r[1] <= gray2bin(bits_sync_r);
	end

	a_err_holds_status: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b)
		o_error |=> o_status_b_oe || !req_b || state_r == ST_RELEASE)
		else $error("status not held low in error");
	a_user_needs_done: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b)
		$rose(o_user_mode) |-> $past(state_r) == ST_INIT && done_s_r[1])
		else $error("user mode without done");
	a_req_abandons: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b)
		o_user_mode && !req_b |=> state_r == ST_RESET)
		else $error("request low did not reset");
	a_cable_no_restart: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b)
		o_error && cab_in && req_b |=> o_error)
		else $error("cable load restarted");
	a_stat_low_no_accept: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b)
		!stat_b |=> !accept_r)
		else $error("accepting with status low");
	a_held_status_waits: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b)
		state_r == ST_RELEASE && !stat_b && req_b |=> state_r == ST_RELEASE)
		else $error("left release with status held");
	a_held_req_waits: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b)
		!req_b |=> state_r == ST_RESET)
		else $error("started during request low");
	a_usr_init_len: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b)
		$rose(o_user_mode) && use_usr |-> $past(cnt_r) >= USR_INIT_CYC)
		else $error("short user clock init");
endmodule : passive_config_receiver

// ==== verif/cfg_host.sv ====
`timescale 1ns/1ps
module cfg_host
(
	input  wire logic       i_status_b,
	input  wire logic       i_done,
	output logic            o_cfg_clk,
	output logic [7:0]      o_data
);
	integer seed = 32'h407C1D5B;

	initial
	begin
		o_cfg_clk = 1'b0;
		o_data = 8'h00;
	end

	// One link cycle, data changed while clock low
	task automatic pulse();
		o_data = 8'($random(seed));
		#15 o_cfg_clk = 1'b1;
		#15 o_cfg_clk = 1'b0;
	endtask : pulse

	// Clock runs n link cycles, then data flips while the clock stays low
	task automatic burst(input int n);
		repeat (n) pulse();
		o_data = ~o_data;
	endtask : burst

	task automatic load();
		int i;
		for (i = 0; i < 4000 && i_status_b !== 1'b1; i++)
			#10;
		for (i = 0; i < 2000 && i_done !== 1'b1 && i_status_b === 1'b1; i++)
			pulse();
		if (i_done === 1'b1)
			burst(2);
		else
			o_data = ~o_data;
	endtask : load
endmodule : cfg_host

// ==== verif/tb.sv ====
`timescale 1ns/1ps
module tb;
	import cfg_rx_pkg::*;
	logic       i_clk_sys, i_rst_b, usr_clk, usr_run, par, cab, sel, auto;
	logic       req_b, crc, hold_b, cfg_clk, st_oe, dn_oe, user, err, um_d, er_d;
	logic [7:0] data;
	logic [2:0] exp_q[$];
	int         miscompares, n_checks, k;
	wire        st_w = ~st_oe & hold_b;

	passive_config_receiver #(.RELEASE_CYC(20), .STARTUP_CYC(30),
		.IMAGE_BITS(32'h0000_0020)) u_dut (.i_clk_sys(i_clk_sys), .i_rst_b(i_rst_b),
		.i_cfg_clk(cfg_clk), .i_user_startup_clock(usr_clk), .i_mode_parallel(par),
		.i_cable_load(cab), .i_usr_clk_sel(sel), .i_auto_restart(auto),
		.i_config_req_b(req_b), .i_status_b(st_w), .i_done(~dn_oe), .i_data(data),
		.i_crc_error(crc), .o_status_b_oe(st_oe), .o_status_b_out(), .o_done_oe(dn_oe),
		.o_done_out(), .o_user_mode(user), .o_error(err));
	cfg_host u_host (.i_status_b(st_w), .i_done(~dn_oe), .o_cfg_clk(cfg_clk), .o_data(data));

	initial
	begin
		i_clk_sys = 1'b0;
		forever #10 i_clk_sys = ~i_clk_sys;
	end
	initial
	begin
		usr_clk = 1'b0;
		forever #25 usr_clk = usr_run ? ~usr_clk : 1'b0;
	end
	initial u_host.burst(4);
	initial
	begin
		#1000000 miscompares++;
		final_report();
	end

	task automatic check(input string nm, input logic [2:0] e, input logic [2:0] g);
		n_checks++;
		if (g !== e)
		begin
			miscompares++;
			$display("unexpected %s exp %b got %b", nm, e, g);
		end
	endtask : check

	// Result watcher
	always @(posedge i_clk_sys)
	begin
		if ((user && !um_d) || (err && !er_d))
			check("event", exp_q.size() ? exp_q.pop_front() : 3'b111, {dn_oe, user, err});
		um_d <= user;
		er_d <= err;
	end

	task automatic run(input logic [3:0] cfg, input int hold, input logic c, input logic [2:0] e);
		@(posedge i_clk_sys);
		#1 {par, cab, sel, auto} = cfg;
		req_b = 1'b0;
		hold_b = (hold == 0);
		repeat (5) @(posedge i_clk_sys);
		check("abandon", 3'b100, {dn_oe, user, err});
		#1 req_b = 1'b1;
		crc = c;
		if (hold != 0)
		begin
			repeat (hold) @(posedge i_clk_sys);
			u_host.burst(40);
			@(posedge i_clk_sys);
			check("refused", 3'b100, {dn_oe, user, err});
			#1 hold_b = 1'b1;
		end
		exp_q.push_back(e);
		u_host.load();
		for (k = 0; k < 20000 && !(user | err); k++)
			@(posedge i_clk_sys);
		repeat (3) @(posedge i_clk_sys);
	endtask : run

	task automatic final_report();
		if (miscompares == 0 && n_checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask : final_report

	initial
	begin
		{par, cab, sel, auto, crc, usr_run, um_d, er_d} = 8'h00;
		req_b = 1'b1;
		hold_b = 1'b1;
		i_rst_b = 1'b0;
		miscompares = 0;
		n_checks = 0;
		repeat (3) @(posedge i_clk_sys);
		#1 i_rst_b = 1'b1;
		run(4'b0000, 0, 1'b0, 3'b010);
		check("startup", 3'b001, 3'(k >= 20 && k <= 45));
		run(4'b1000, 0, 1'b0, 3'b010);
		run(4'b0110, 0, 1'b0, 3'b010);
		usr_run = 1'b1;
		run(4'b0010, 0, 1'b0, 3'b010);
		check("usr_init", 3'b001, 3'(k >= 2 * USR_INIT_CYC));
		usr_run = 1'b0;
		run(4'b0000, 100, 1'b0, 3'b010);
		run(4'b0101, 0, 1'b1, 3'b101);
		repeat (200) @(posedge i_clk_sys);
		check("no_restart", 3'b011, {1'b0, st_oe, err});
		run(4'b0000, 0, 1'b0, 3'b010);
		check("pending", 3'b000, 3'(exp_q.size()));
		final_report();
	end
endmodule : tb
